// ---- verif/nv_store_recall_seq_bench.sv ----
`default_nettype none
module nv_store_recall_seq_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SHORT = 20;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic lowSupplyPin = 1'b0;
    logic busStop = 1'b0;
    logic wakeReq = 1'b0;
    logic pressReq = 1'b0;
    logic [7:0] pressLen = 8'h01;
    logic hwSavePinOut, hwSavePinOe, pinLevel, holding;
    logic memRdEn, memWrEn, storeActive, recallActive;
    nv_seq_pkg::cmd_req_t cmdReq = '0;
    nv_seq_pkg::mem_req_t memReq = '0;
    nv_seq_pkg::nv_status_t status;
    logic [2:0] expQ[$];
    logic [2:0] evPrev = 3'h0;
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;
    int oeRun = 0;
    int seed = 32'h3a0d;
    int n;

    nv_store_recall_seq #(.STORE_CYC(SHORT), .RECALL_CYC(SHORT), .SLEEP_CYC(SHORT),
        .WAKE_LOW_CYC(2 * SHORT), .WAKE_STD_CYC(SHORT)) i_dut (
        .clk(clk), .nrst(nrst), .lowSupplyPin(lowSupplyPin), .hwSavePinIn(pinLevel),
        .hwSavePinOut(hwSavePinOut), .hwSavePinOe(hwSavePinOe), .cmdReq(cmdReq),
        .memReq(memReq), .busStop(busStop), .wakeReq(wakeReq), .memRdEn(memRdEn),
        .memWrEn(memWrEn), .storeActive(storeActive), .recallActive(recallActive),
        .status(status)
    );
    save_pin_host i_host (
        .clk(clk), .pressReq(pressReq), .pressLen(pressLen), .devOut(hwSavePinOut),
        .devOe(hwSavePinOe), .pinLevel(pinLevel), .holding(holding)
    );

    initial begin
        forever #50 clk = ~clk;
    end

    // ------------------------------------------------------------
    // comparison, waiting and closing
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    function automatic logic cond(input int sel);
        case (sel)
            0: return memRdEn === 1'b1;
            1: return storeActive === 1'b0 && recallActive === 1'b0 && memRdEn === 1'b1
                      && expQ.size() == 0;
            2: return status.standby === 1'b1;
            3: return memRdEn === 1'b0;
            default: return holding === 1'b0;
        endcase
    endfunction

    task automatic waitFor(input int sel, input int limit, output int cnt);
        cnt = 0;
        while (!cond(sel) && cnt <= limit) begin
            tick(1);
            cnt++;
        end
    endtask

    task automatic results();
        if (n_errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // monitor: rising operation flags against the noted order
    // ------------------------------------------------------------
    always @(posedge clk) begin
        logic [2:0] ev;
        ev = {status.sleeping, recallActive, storeActive};
        if (nrst && (ev & ~evPrev) != 3'h0) begin
            if (expQ.size() == 0) check("unexpected operation", {5'h0, ev}, 8'h00);
            else check("operation", {5'h0, ev & ~evPrev}, {5'h0, expQ.pop_front()});
        end
        evPrev = ev;
        oeRun = (hwSavePinOe === 1'b1) ? oeRun + 1 : 0;
        if (oeRun > 5) check("high drive cycles", 8'(oeRun), 8'h05);
        if (hwSavePinOe === 1'b1) check("driven level", {7'h0, hwSavePinOut}, 8'h01);
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            results();
        end
    end

    // ------------------------------------------------------------
    // save by pin or by supply loss, with or without a prior write
    // ------------------------------------------------------------
    task automatic save(input logic viaPin, input logic dirty, input int hold);
        int k;
        if (dirty) begin
            repeat (4) begin
                memReq = nv_seq_pkg::mem_req_t'(2'($random(seed)));
                tick(1);
            end
            memReq = 2'b01;
            tick(1);
            memReq = '0;
            expQ.push_back(3'b001);
        end
        if (viaPin) begin
            pressLen = 8'(hold);
            pressReq = 1'b1;
            tick(1);
            pressReq = 1'b0;
        end else begin
            lowSupplyPin = 1'b1;
        end
        waitFor(3, 6, k);
        check("access cut", {7'h0, memRdEn}, 8'h00);
        if (dirty) check("write grace", {7'h0, memWrEn}, 8'h01);
        tick(2);
        if (dirty) check("write blocked", {6'h0, memWrEn, storeActive}, 8'h01);
        tick(hold - 10);
        check("still locked", {6'h0, memRdEn, memWrEn}, 8'h00);
        if (viaPin) waitFor(4, 20, k);
        lowSupplyPin = 1'b0;
        waitFor(1, 60, k);
        check("back to access", {7'h0, k <= 50}, 8'h01);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        tick(16);
        nrst = 1'b1;
        tick(4);
        check("after reset", {4'h0, status.readyNow, memRdEn, memWrEn, hwSavePinOe}, 8'h0e);
        save(1'b1, 1'b0, 12);
        save(1'b1, 1'b1, 40);
        save(1'b0, 1'b1, 40);
        save(1'b0, 1'b0, 12);
        for (int c = 1; c <= 3; c++) begin
            cmdReq = '{valid: 1'b1, cmd: nv_seq_pkg::sw_cmd_t'(3'(c))};
            tick(1);
            cmdReq = '0;
            expQ.push_back(3'(1 << (c - 1)));
            tick(2);
            if (c < 3) check("io lockout", {6'h0, memRdEn, memWrEn}, 8'h00);
            if (c < 3) check("busy", {7'h0, status.busy}, 8'h01);
            if (c == 3) begin
                check("sleeping", {7'h0, status.sleeping}, 8'h01);
                tick(5);
                wakeReq = 1'b1;
                tick(1);
                wakeReq = 1'b0;
                tick(SHORT - 4);
                check("early access", {7'h0, memRdEn}, 8'h00);
                tick(4);
                check("wake ready", {7'h0, memRdEn}, 8'h01);
            end
            waitFor(1, 2 * SHORT + 10, n);
            check("finish in time", {7'h0, n <= SHORT + 10}, 8'h01);
        end
        cmdReq = '{valid: 1'b1, cmd: nv_seq_pkg::CMD_STORE};
        tick(1);
        cmdReq = '{valid: 1'b1, cmd: nv_seq_pkg::CMD_RECALL};
        tick(1);
        cmdReq = '0;
        expQ.push_back(3'b001);
        expQ.push_back(3'b010);
        tick(3);
        waitFor(1, 3 * SHORT + 20, n);
        check("pending command done", {7'h0, n <= 3 * SHORT + 20}, 8'h01);
        busStop = 1'b1;
        tick(1);
        busStop = 1'b0;
        waitFor(2, 1010, n);
        check("standby time", {7'h0, n <= 1000}, 8'h01);
        busStop = 1'b1;
        tick(1);
        busStop = 1'b0;
        tick(5);
        check("noted operations left", 8'(expQ.size()), 8'h00);
        results();
    end
endmodule
`default_nettype wire

// ---- verif/save_pin_host.sv ----
`default_nettype none
// host side of the save pin: pulls it low on request, else the pull-up wins; the device driver overrides both while enabled
module save_pin_host (
    // clock
    input wire logic clk,
    // request from the bench
    input wire logic pressReq,
    input wire logic [7:0] pressLen,
    // device side of the pin
    input wire logic devOut,
    input wire logic devOe,
    // resolved pin
    output logic pinLevel,
    output logic holding
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] left = 8'h00;

    // low for whole cycles only, so never shorter than 100 ns
    always @(posedge clk) begin
        if (pressReq && left == 8'h00) begin
            left <= (pressLen == 8'h00) ? 8'h01 : pressLen;
        end else if (left != 8'h00) begin
            left <= left - 8'h01;
        end
    end
    assign holding = (left != 8'h00);
    // device driver wins while enabled, otherwise host low or pull-up high
    assign pinLevel = (devOe === 1'b1) ? devOut : !holding;
endmodule
`default_nettype wire

// ---- verilog/nv_delay_counter.sv ----
`default_nettype none
// loadable down counter; done pulses for one cycle when it reaches zero
module nv_delay_counter #(
    parameter int WIDTH = 24
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // control
    input wire logic load,
    input wire logic [WIDTH-1:0] loadValue,
    input wire logic abort,
    // status
    output logic running,
    output logic done
);
    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic run;
        logic fin;
    } cnt_state_t;

    cnt_state_t cur_ff;
    cnt_state_t nxt_ff;

    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.fin = 1'b0;
        if (abort) begin
            nxt_ff.run = 1'b0;
            nxt_ff.count = '0;
        end else if (load) begin
            nxt_ff.run = 1'b1;
            nxt_ff.count = loadValue;
        end else if (cur_ff.run) begin
            if (cur_ff.count <= WIDTH'(1)) begin
                nxt_ff.run = 1'b0;
                nxt_ff.fin = 1'b1;
                nxt_ff.count = '0;
            end else begin
                nxt_ff.count = cur_ff.count - WIDTH'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign running = cur_ff.run;
    assign done = cur_ff.fin;
endmodule
`default_nettype wire

// ---- verilog/nv_seq_params.svh ----
`ifndef NV_SEQ_PARAMS_SVH
`define NV_SEQ_PARAMS_SVH
// clock period in ns (10 MHz)
`define NV_CLK_NS 100
// timing figures, in their printed units
`define NV_WRITE_GRACE_NS 25
`define NV_SEQ_PROC_US 500
`define NV_SAVE_PULSE_NS 15
`define NV_RELEASE_ACTIVE_US 5
`define NV_HIGH_DRIVE_NS 500
`define NV_SLEEP_ENTRY_MS 8
`define NV_WAKE_LOW_MS 40
`define NV_WAKE_STD_MS 20
`define NV_STANDBY_US 100
`define NV_STORE_MS 8
`define NV_RECALL_US 600
// cycle counts: integer division rounds every time down; only the grace count is held to one cycle at least
`define NV_GRACE_CYC (((`NV_WRITE_GRACE_NS / `NV_CLK_NS) < 1) ? 1 : (`NV_WRITE_GRACE_NS / `NV_CLK_NS))
`define NV_SEQ_CYC ((`NV_SEQ_PROC_US * 1000) / `NV_CLK_NS)
`define NV_RELEASE_CYC ((`NV_RELEASE_ACTIVE_US * 1000) / `NV_CLK_NS)
`define NV_HIGH_DRIVE_CYC ((`NV_HIGH_DRIVE_NS / `NV_CLK_NS) - 1)
`define NV_SLEEP_CYC ((`NV_SLEEP_ENTRY_MS * 1000000) / `NV_CLK_NS)
`define NV_WAKE_LOW_CYC ((`NV_WAKE_LOW_MS * 1000000) / `NV_CLK_NS)
`define NV_WAKE_STD_CYC ((`NV_WAKE_STD_MS * 1000000) / `NV_CLK_NS)
`define NV_STANDBY_CYC ((`NV_STANDBY_US * 1000) / `NV_CLK_NS)
`define NV_STORE_CYC ((`NV_STORE_MS * 1000000) / `NV_CLK_NS)
`define NV_RECALL_CYC ((`NV_RECALL_US * 1000) / `NV_CLK_NS)
`endif

// ---- verilog/nv_seq_pkg.sv ----
`default_nettype none
package nv_seq_pkg;
    typedef enum logic [6:0] {
        ST_IDLE    = 7'b000_0001,
        ST_GRACE   = 7'b000_0010,
        ST_STORE   = 7'b000_0100,
        ST_RECALL  = 7'b000_1000,
        ST_HIGHDRV = 7'b001_0000,
        ST_RELEASE = 7'b010_0000,
        ST_SLEEP   = 7'b100_0000
    } op_state_t;

    typedef enum logic [2:0] {
        CMD_NONE   = 3'h0,
        CMD_STORE  = 3'h1,
        CMD_RECALL = 3'h2,
        CMD_SLEEP  = 3'h3
    } sw_cmd_t;

    // one host command, handed over when the bus sequence completes
    typedef struct packed {
        logic valid;
        sw_cmd_t cmd;
    } cmd_req_t;

    // memory access request from the serial front end
    typedef struct packed {
        logic rd;
        logic wr;
    } mem_req_t;

    typedef struct packed {
        logic readyNow;
        logic standby;
        logic sleeping;
        logic busy;
    } nv_status_t;
endpackage
`default_nettype wire

// ---- verilog/nv_store_recall_seq.sv ----
`include "nv_seq_params.svh"
`default_nettype none
module nv_store_recall_seq #(
    parameter bit LOW_VOLT_PART = 1'b0,
    parameter int STORE_CYC = `NV_STORE_CYC,
    parameter int RECALL_CYC = `NV_RECALL_CYC,
    parameter int SEQ_CYC = `NV_SEQ_CYC,
    parameter int SLEEP_CYC = `NV_SLEEP_CYC,
    parameter int WAKE_LOW_CYC = `NV_WAKE_LOW_CYC,
    parameter int WAKE_STD_CYC = `NV_WAKE_STD_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // pins from outside the clock domain
    input wire logic lowSupplyPin,
    input wire logic hwSavePinIn,
    output logic hwSavePinOut,
    output logic hwSavePinOe,
    // serial front end, same clock
    input wire nv_seq_pkg::cmd_req_t cmdReq,
    input wire nv_seq_pkg::mem_req_t memReq,
    input wire logic busStop,
    input wire logic wakeReq,
    // memory array control
    output logic memRdEn,
    output logic memWrEn,
    output logic storeActive,
    output logic recallActive,
    output nv_seq_pkg::nv_status_t status
);
    localparam int CW = 24;
    localparam logic [CW-1:0] GRACE_LD = CW'(`NV_GRACE_CYC);
    localparam logic [CW-1:0] HIGH_LD = CW'(`NV_HIGH_DRIVE_CYC);
    localparam logic [CW-1:0] REL_LD = CW'(`NV_RELEASE_CYC);
    // the flags fed by done are registered one cycle after the counter reaches zero, so load one less
    localparam logic [CW-1:0] SB_LD = CW'(`NV_STANDBY_CYC - 1);
    localparam logic [CW-1:0] WAKE_LD = LOW_VOLT_PART ? CW'(WAKE_LOW_CYC - 1)
                                                      : CW'(WAKE_STD_CYC - 1);

    typedef struct packed {
        logic [1:0] lvSync;
        logic [1:0] pinSync;
        nv_seq_pkg::op_state_t state;
        logic dirty;
        logic fromPin;
        logic powerSave;
        nv_seq_pkg::sw_cmd_t pendCmd;
        logic cmdPending;
        logic waking;
        logic standby;
        logic memRd;
        logic memWr;
        logic pinOut;
        logic pinOe;
    } seq_state_t;

    seq_state_t cur_ff;
    seq_state_t nxt_ff;

    logic cntLoad;
    logic [CW-1:0] cntValue;
    logic cntRunning;
    logic cntDone;
    logic pinLow;
    logic lowSupply;
    logic lowSupplyPrev;

    nv_delay_counter #(
        .WIDTH(CW)
    ) u_cnt (
        .clk(clk),
        .nrst(nrst),
        .load(cntLoad),
        .loadValue(cntValue),
        .abort(1'b0),
        .running(cntRunning),
        .done(cntDone)
    );

    // -------------------------------------------------------
    // synchronised pins
    // -------------------------------------------------------
    assign lowSupply = cur_ff.lvSync[1];
    assign pinLow = !cur_ff.pinSync[1];
    assign lowSupplyPrev = cur_ff.powerSave;

    // -------------------------------------------------------
    // sequencing
    // -------------------------------------------------------
    always_comb begin
        nxt_ff = cur_ff;
        cntLoad = 1'b0;
        cntValue = '0;
        nxt_ff.lvSync = {cur_ff.lvSync[0], lowSupplyPin};
        nxt_ff.pinSync = {cur_ff.pinSync[0], hwSavePinIn};
        // power-loss edge is remembered via powerSave
        nxt_ff.powerSave = lowSupply;
        if (cmdReq.valid && cmdReq.cmd != nv_seq_pkg::CMD_NONE) begin
            nxt_ff.cmdPending = 1'b1;
            nxt_ff.pendCmd = cmdReq.cmd;
        end
        if (busStop) begin
            nxt_ff.standby = 1'b0;
        end
        if (memReq.wr && cur_ff.memWr) begin
            nxt_ff.dirty = 1'b1;
        end
        case (cur_ff.state)
            nv_seq_pkg::ST_IDLE: begin
                if (lowSupply && !lowSupplyPrev) begin
                    nxt_ff.fromPin = 1'b0;
                    if (cur_ff.dirty) begin
                        nxt_ff.state = nv_seq_pkg::ST_GRACE;
                        cntLoad = 1'b1;
                        cntValue = GRACE_LD;
                    end
                end else if (pinLow) begin
                    nxt_ff.fromPin = 1'b1;
                    if (cur_ff.dirty) begin
                        nxt_ff.state = nv_seq_pkg::ST_GRACE;
                        cntLoad = 1'b1;
                        cntValue = GRACE_LD;
                    end else begin
                        nxt_ff.state = nv_seq_pkg::ST_RELEASE;
                    end
                end else if (cur_ff.cmdPending && !cur_ff.waking) begin
                    // taken in one cycle; a command arriving now stays pending behind it
                    nxt_ff.cmdPending = cmdReq.valid && cmdReq.cmd != nv_seq_pkg::CMD_NONE;
                    case (cur_ff.pendCmd)
                        nv_seq_pkg::CMD_STORE: begin
                            nxt_ff.fromPin = 1'b0;
                            nxt_ff.state = nv_seq_pkg::ST_STORE;
                            cntLoad = 1'b1;
                            cntValue = CW'(STORE_CYC);
                        end
                        nv_seq_pkg::CMD_RECALL: begin
                            nxt_ff.state = nv_seq_pkg::ST_RECALL;
                            cntLoad = 1'b1;
                            cntValue = CW'(RECALL_CYC);
                        end
                        nv_seq_pkg::CMD_SLEEP: begin
                            nxt_ff.state = nv_seq_pkg::ST_SLEEP;
                            cntLoad = 1'b1;
                            cntValue = CW'(SLEEP_CYC);
                        end
                        default: begin
                            nxt_ff.state = nv_seq_pkg::ST_IDLE;
                        end
                    endcase
                end
            end
            nv_seq_pkg::ST_GRACE: begin
                if (cntDone) begin
                    nxt_ff.state = nv_seq_pkg::ST_STORE;
                    cntLoad = 1'b1;
                    cntValue = CW'(STORE_CYC);
                end
            end
            nv_seq_pkg::ST_STORE: begin
                if (cntDone) begin
                    nxt_ff.dirty = 1'b0;
                    nxt_ff.state = cur_ff.fromPin ? nv_seq_pkg::ST_RELEASE
                                                  : nv_seq_pkg::ST_IDLE;
                end
            end
            nv_seq_pkg::ST_RECALL: begin
                if (cntDone) begin
                    nxt_ff.dirty = 1'b0;
                    nxt_ff.state = nv_seq_pkg::ST_IDLE;
                end
            end
            nv_seq_pkg::ST_RELEASE: begin
                // wait for the external driver to let go, then drive high briefly
                if (!pinLow) begin
                    nxt_ff.state = nv_seq_pkg::ST_HIGHDRV;
                    cntLoad = 1'b1;
                    cntValue = HIGH_LD;
                end
            end
            nv_seq_pkg::ST_HIGHDRV: begin
                if (cntDone || !cntRunning) begin
                    nxt_ff.state = nv_seq_pkg::ST_IDLE;
                end
            end
            nv_seq_pkg::ST_SLEEP: begin
                if (wakeReq) begin
                    nxt_ff.state = nv_seq_pkg::ST_IDLE;
                    nxt_ff.waking = 1'b1;
                    cntLoad = 1'b1;
                    cntValue = WAKE_LD;
                end
            end
            default: begin
                nxt_ff.state = nv_seq_pkg::ST_IDLE;
            end
        endcase
        if (cur_ff.waking && cntDone) begin
            nxt_ff.waking = 1'b0;
        end
        if (busStop && nxt_ff.state == nv_seq_pkg::ST_IDLE && !cntLoad) begin
            cntLoad = 1'b1;
            cntValue = SB_LD;
        end
        if (cur_ff.state == nv_seq_pkg::ST_IDLE && cntDone && !cur_ff.waking) begin
            nxt_ff.standby = 1'b1;
        end
        // access gating: writes stay open through the grace window only
        nxt_ff.memRd = (nxt_ff.state == nv_seq_pkg::ST_IDLE) && !nxt_ff.waking
                       && !lowSupply && !pinLow;
        nxt_ff.memWr = ((nxt_ff.state == nv_seq_pkg::ST_IDLE) && !nxt_ff.waking
                        && !lowSupply && !pinLow)
                       || (nxt_ff.state == nv_seq_pkg::ST_GRACE);
        nxt_ff.pinOut = 1'b1;
        nxt_ff.pinOe = (nxt_ff.state == nv_seq_pkg::ST_HIGHDRV);
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cur_ff <= '{lvSync: 2'b00, pinSync: 2'b11, state: nv_seq_pkg::ST_IDLE,
                        pendCmd: nv_seq_pkg::CMD_NONE, default: 1'b0};
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // -------------------------------------------------------
    // outputs
    // -------------------------------------------------------
    assign hwSavePinOut = cur_ff.pinOut;
    assign hwSavePinOe = cur_ff.pinOe;
    assign memRdEn = cur_ff.memRd;
    assign memWrEn = cur_ff.memWr;
    assign storeActive = (cur_ff.state == nv_seq_pkg::ST_STORE);
    assign recallActive = (cur_ff.state == nv_seq_pkg::ST_RECALL);
    assign status = '{readyNow: cur_ff.memRd, standby: cur_ff.standby,
                      sleeping: (cur_ff.state == nv_seq_pkg::ST_SLEEP),
                      busy: (cur_ff.state != nv_seq_pkg::ST_IDLE) || cur_ff.waking};

    // -------------------------------------------------------
    // checks
    // -------------------------------------------------------
    property p_nodirty;
        @(posedge clk) disable iff (!nrst)
        (cur_ff.state == nv_seq_pkg::ST_IDLE && pinLow && !cur_ff.dirty && !lowSupply)
        |=> (cur_ff.state != nv_seq_pkg::ST_STORE);
    endproperty
    a_nodirty: assert property (p_nodirty) else $error("clean save not skipped");

    property p_grace;
        @(posedge clk) disable iff (!nrst)
        (cur_ff.state == nv_seq_pkg::ST_GRACE) |-> memWrEn;
    endproperty
    a_grace: assert property (p_grace) else $error("write blocked in grace");

    property p_lock;
        @(posedge clk) disable iff (!nrst)
        (storeActive || recallActive) |-> (!memRdEn && !memWrEn);
    endproperty
    a_lock: assert property (p_lock) else $error("access during save or restore");

    property p_cmd;
        @(posedge clk) disable iff (!nrst)
        (cmdReq.valid && cmdReq.cmd == nv_seq_pkg::CMD_STORE && !status.busy && !cur_ff.cmdPending
         && !pinLow && !lowSupply && cur_ff.powerSave == lowSupply)
        |-> ##[1:3] storeActive;
    endproperty
    a_cmd: assert property (p_cmd) else $error("store command not acted on");

    property p_pinlow;
        @(posedge clk) disable iff (!nrst)
        pinLow |=> !memRdEn;
    endproperty
    a_pinlow: assert property (p_pinlow) else $error("access while save pin low");

    property p_release;
        @(posedge clk) disable iff (!nrst)
        (cur_ff.state == nv_seq_pkg::ST_RELEASE && !pinLow && !lowSupply)
        |-> ##[1:8] (cur_ff.state == nv_seq_pkg::ST_IDLE);
    endproperty
    a_release: assert property (p_release) else $error("not active after release");

    property p_highdrv;
        @(posedge clk) disable iff (!nrst)
        $rose(hwSavePinOe) |-> ##[1:5] !hwSavePinOe;
    endproperty
    a_highdrv: assert property (p_highdrv) else $error("save pin driven too long");

    property p_drvhigh;
        @(posedge clk) disable iff (!nrst)
        hwSavePinOe |-> hwSavePinOut;
    endproperty
    a_drvhigh: assert property (p_drvhigh) else $error("save pin driven low");
endmodule
`default_nettype wire
